// file: hdl/can_mode_map.svh
`ifndef CAN_MODE_MAP_SVH
`define CAN_MODE_MAP_SVH
// Summary of operation
// - Triple sampling votes three samples before point.
// - Secondary transmit is complement or controller clock.
// - Source select enables pin; disable returns GPIO.
// - Time-stamp enable routes reception to capture unit.
// - Wake filter enable low-passes wake receive path.
// - Three functional modes: legacy, enhanced, FIFO.
// - Five operation modes chosen by request field.
// - Reported mode follows request only when accepted.
// - Phase two automatic or host-programmed value.
// - Six buffers each transmitter or receiver, enhanced.
// - Bus activity wakes controller from Sleep.
`define OPM_NORMAL      3'h0
`define OPM_SLEEP       3'h1
`define OPM_LOOPBACK    3'h2
`define OPM_LISTEN      3'h3
`define OPM_CONFIG      3'h4
`define FMODE_LEGACY    2'h0
`define FMODE_ENHANCED  2'h1
`define FMODE_FIFO      2'h2
`define PHASE_SEGMENT_TWO_MIN      3'h0
`define PHASE_SEGMENT_TWO_AUTO_VAL 3'h1
`define WAKE_FILT_LEN   4
`define NUM_PROG_BUF    6
`endif

// file: hdl/can_mode_pkg.sv
package can_mode_pkg;
  typedef enum logic [2:0] {
    ST_CONFIG = 3'h0,
    ST_WAIT   = 3'h1,
    ST_RUN    = 3'h3
  } accept_state_t;
  typedef struct packed {
    logic       triple_sample_select;
    logic       phase2_manual_select;
    logic [2:0] phase_segment_two;
    logic [1:0] func_mode;
    logic       wake_lowpass_enable;
    logic       wake_enable;
    logic       timestamp_enable;
  } cfg_t;
endpackage

// file: hdl/can_mode_and_config_control.sv
`include "can_mode_map.svh"
module can_mode_and_config_control #(
  parameter int NUM_BUF  = `NUM_PROG_BUF,
  parameter int FILT_LEN = `WAKE_FILT_LEN
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic [2:0]           op_mode_req,
  input  wire logic                 cfg_we,
  input  wire can_mode_pkg::cfg_t   cfg_in,
  input  wire logic [NUM_BUF-1:0]   buf_tx_select,
  input  wire logic                 tx_secondary_src_clock,
  input  wire logic                 tx_secondary_src_we,
  input  wire logic                 tx_secondary_disable,
  input  wire logic                 frame_busy,
  input  wire logic                 frame_received,
  input  wire logic                 can_tx_core,
  input  wire logic                 can_rx,
  input  wire logic                 sample_tick,
  input  wire logic                 sample_point,
  input  wire logic                 can_clk_level,
  output logic [2:0]                op_mode_active,
  output can_mode_pkg::cfg_t        cfg_active,
  output logic [NUM_BUF-1:0]        buf_is_tx,
  output logic [2:0]                phase2_eff,
  output logic                      rx_bit,
  output logic                      can_tx_primary,
  output logic                      can_tx_secondary,
  output logic                      can_tx_secondary_oe,
  output logic                      capture_compare_unit,
  output logic                      wake_event
);

  // The filter history needs at least two stages to shift.
  if (NUM_BUF < 1 || NUM_BUF > 16 || FILT_LEN < 2 || FILT_LEN > 16) begin : g_param_check
    $error("Unsupported parameter values.");
  end

  can_mode_pkg::accept_state_t st_r, st_nxt;
  logic [2:0]         mode_r, mode_nxt;
  can_mode_pkg::cfg_t cfg_r, cfg_nxt;
  logic [NUM_BUF-1:0] btx_r, btx_nxt;
  logic               src_r, src_nxt, oe_r, oe_nxt;
  logic [2:0]         smp_r, smp_nxt;
  logic               bit_r, bit_nxt;
  logic [FILT_LEN-1:0] flt_r, flt_nxt;
  logic               rxf_r, rxf_nxt, rxf_d_r;
  logic               tx1_r, tx2_r, cap_r, wake_r;
  logic               tx1_nxt, tx2_nxt, cap_nxt, wake_nxt;
  logic [2:0]         ph2_r, ph2_nxt;
  logic               vote;
  logic               act;

  // Mode acceptance: a change out of Normal is deferred while a frame is on the bus.
  always_comb begin
    st_nxt   = st_r;
    mode_nxt = mode_r;
    if (op_mode_req != mode_r) begin
      if (mode_r == `OPM_NORMAL && frame_busy) begin
        st_nxt = can_mode_pkg::ST_WAIT;
      end else if (op_mode_req <= `OPM_CONFIG) begin
        mode_nxt = op_mode_req;
        st_nxt   = (op_mode_req == `OPM_CONFIG) ? can_mode_pkg::ST_CONFIG
                                                : can_mode_pkg::ST_RUN;
      end
    end else if (mode_r == `OPM_CONFIG) begin
      st_nxt = can_mode_pkg::ST_CONFIG;
    end else begin
      st_nxt = can_mode_pkg::ST_RUN;
    end
    // Bus activity pulls the controller out of Sleep into Normal.
    if (mode_r == `OPM_SLEEP && cfg_r.wake_enable && act) begin
      mode_nxt = `OPM_NORMAL;
    end
  end

  // Configuration writes are honoured only in Configuration mode.
  always_comb begin
    cfg_nxt = cfg_r;
    btx_nxt = btx_r;
    if (cfg_we && mode_r == `OPM_CONFIG) begin
      cfg_nxt = cfg_in;
      if (cfg_in.func_mode == 2'h3) begin
        cfg_nxt.func_mode = `FMODE_LEGACY;
      end
      if (cfg_in.func_mode != `FMODE_LEGACY && cfg_in.func_mode != 2'h3) begin
        btx_nxt = buf_tx_select;
      end
    end
    if (cfg_r.func_mode == `FMODE_LEGACY) begin
      btx_nxt = '0;
    end
    ph2_nxt = cfg_r.phase2_manual_select ? cfg_r.phase_segment_two
                                         : `PHASE_SEGMENT_TWO_AUTO_VAL;
  end

  // Disable wins over a source write, so a pin can be parked in one cycle.
  // Secondary pin source and ownership.
  always_comb begin
    src_nxt = src_r;
    oe_nxt  = oe_r;
    if (tx_secondary_disable) begin
      oe_nxt = 1'b0;
    end else if (tx_secondary_src_we) begin
      src_nxt = tx_secondary_src_clock;
      oe_nxt  = 1'b1;
    end
  end

  // The history shifts only on sample_tick, so it holds between bit slots.
  // Sampling: three samples before the point are voted, else one at it.
  assign vote = (smp_r[0] & smp_r[1]) | (smp_r[1] & smp_r[2]) | (smp_r[0] & smp_r[2]);
  always_comb begin
    smp_nxt = sample_tick ? {smp_r[1:0], can_rx} : smp_r;
    bit_nxt = bit_r;
    if (sample_point) begin
      bit_nxt = cfg_r.triple_sample_select ? vote : can_rx;
    end
  end

  // Wake filter: a dominant level must persist FILT_LEN cycles; the
  // trade is a slower wake for immunity to short glitches.
  always_comb begin
    flt_nxt = {flt_r[FILT_LEN-2:0], ~can_rx};
    rxf_nxt = cfg_r.wake_lowpass_enable ? (&flt_r) : ~can_rx;
  end
  assign act = rxf_r & ~rxf_d_r;

  // Pin and pulse outputs; the primary pin idles recessive outside the sending modes.
  always_comb begin
    tx1_nxt  = (mode_r == `OPM_NORMAL || mode_r == `OPM_LOOPBACK) ? can_tx_core : 1'b1;
    tx2_nxt  = src_r ? can_clk_level : ~tx1_r;
    cap_nxt  = cfg_r.timestamp_enable & frame_received;
    wake_nxt = (mode_r == `OPM_SLEEP) & cfg_r.wake_enable & act;
  end

  // Mode state; reset leaves the host in Configuration.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r   <= can_mode_pkg::ST_CONFIG;
      mode_r <= `OPM_CONFIG;
    end else begin
      st_r   <= st_nxt;
      mode_r <= mode_nxt;
    end
  end

  // Configuration, buffer roles and effective phase two.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_r <= '0;
      btx_r <= '0;
      ph2_r <= `PHASE_SEGMENT_TWO_AUTO_VAL;
    end else begin
      cfg_r <= cfg_nxt;
      btx_r <= btx_nxt;
      ph2_r <= ph2_nxt;
    end
  end

  // Secondary pin ownership.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      src_r <= 1'b0;
      oe_r  <= 1'b0;
    end else begin
      src_r <= src_nxt;
      oe_r  <= oe_nxt;
    end
  end

  // Bit sampling history; it resets to the recessive level.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      smp_r <= 3'h7;
      bit_r <= 1'b1;
    end else begin
      smp_r <= smp_nxt;
      bit_r <= bit_nxt;
    end
  end

  // Wake filter history and edge detector, idle low like a recessive bus.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flt_r   <= '0;
      rxf_r   <= 1'b0;
      rxf_d_r <= 1'b0;
    end else begin
      flt_r   <= flt_nxt;
      rxf_r   <= rxf_nxt;
      rxf_d_r <= rxf_r;
    end
  end

  // Registered pin and pulse outputs. Every output leaves through a flop,
  // so the primary pin trails the accepted mode by one clock and its complement by two.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx1_r  <= 1'b1;
      tx2_r  <= 1'b0;
      cap_r  <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      tx1_r  <= tx1_nxt;
      tx2_r  <= tx2_nxt;
      cap_r  <= cap_nxt;
      wake_r <= wake_nxt;
    end
  end

  // Port drivers: each is a flop above, with no logic in between.
  assign op_mode_active       = mode_r;
  assign cfg_active           = cfg_r;
  assign buf_is_tx            = btx_r;
  assign phase2_eff           = ph2_r;
  assign rx_bit               = bit_r;
  assign can_tx_primary       = tx1_r;
  assign can_tx_secondary     = tx2_r;
  assign can_tx_secondary_oe  = oe_r;
  assign capture_compare_unit = cap_r;
  assign wake_event           = wake_r;
endmodule // can_mode_and_config_control

// file: tb/can_bus_model.sv
module can_bus_model (
  input  wire logic can_tx_primary,
  input  wire logic remote_dom,
  output logic      can_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  // Wired-AND bus: one dominant node wins, so the released line rests at the recessive high.
  assign can_rx = can_tx_primary & ~remote_dom;
endmodule // can_bus_model

// file: tb/can_mode_chk.sv
module can_mode_chk (
  input wire logic               mclk,
  input wire logic               rst,
  input wire logic [2:0]         op_mode_req,
  input wire logic               frame_busy,
  input wire logic [2:0]         op_mode_active,
  input wire logic               cfg_we,
  input wire can_mode_pkg::cfg_t cfg_active,
  input wire logic               tx_secondary_src_we,
  input wire logic               tx_secondary_disable,
  input wire logic               can_tx_secondary_oe,
  input wire logic               frame_received,
  input wire logic               capture_compare_unit,
  input wire logic [2:0]         phase2_eff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_reset; $fell(rst) |-> op_mode_active == 3'h4; endproperty
  a_reset: assert property (p_reset) else $error("mode not config after reset");
  property p_accept; op_mode_req < 3'h5 && op_mode_req != op_mode_active &&
    !(op_mode_active == 3'h0 && frame_busy) |=> op_mode_active == $past(op_mode_req); endproperty
  a_accept: assert property (p_accept) else $error("mode request not taken");
  property p_busy; op_mode_active == 3'h0 && frame_busy |=> op_mode_active == 3'h0; endproperty
  a_busy: assert property (p_busy) else $error("left normal in frame");
  // Sleep is left out because a bus wake may move the mode out of it.
  property p_bad; op_mode_req > 3'h4 && op_mode_active != 3'h1 |=> $stable(op_mode_active);
  endproperty
  a_bad: assert property (p_bad) else $error("bad mode value taken");
  property p_lock; !(cfg_we && op_mode_active == 3'h4) |=> $stable(cfg_active); endproperty
  a_lock: assert property (p_lock) else $error("config changed outside config");
  property p_oe; tx_secondary_src_we || tx_secondary_disable |=>
    can_tx_secondary_oe == !$past(tx_secondary_disable); endproperty
  a_oe: assert property (p_oe) else $error("secondary pin use wrong");
  property p_stamp; 1 |=> capture_compare_unit ==
    $past(frame_received && cfg_active.timestamp_enable); endproperty
  a_stamp: assert property (p_stamp) else $error("capture pulse wrong");
  property p_ph2; 1 |=> phase2_eff == ($past(cfg_active.phase2_manual_select) ?
    $past(cfg_active.phase_segment_two) : 3'h1); endproperty
  a_ph2: assert property (p_ph2) else $error("phase two value wrong");
endmodule // can_mode_chk
bind can_mode_and_config_control can_mode_chk chk (.*);

// file: tb/can_mode_and_config_control_tb.sv
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", n, e, a); end end
module can_mode_and_config_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0, rst = 1'h1, cfg_we = 1'h0, frame_busy = 1'h0, frame_received = 1'h0;
  logic tx_secondary_src_clock = 1'h0, tx_secondary_src_we = 1'h0, tx_secondary_disable = 1'h0;
  logic can_tx_core = 1'h1, sample_tick = 1'h0, sample_point = 1'h0, can_clk_level = 1'h0;
  logic remote_dom = 1'h0, can_rx, rx_bit, can_tx_primary, can_tx_secondary;
  logic can_tx_secondary_oe, capture_compare_unit, wake_event;
  logic [2:0] op_mode_req = 3'h4, op_mode_active, phase2_eff;
  logic [5:0] buf_tx_select = 6'h2a, buf_is_tx;
  can_mode_pkg::cfg_t cfg_in = '0, cfg_active, c;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  can_mode_and_config_control dut (.*);
  can_bus_model bus (.*);
  initial forever #20 mclk = ~mclk;
  // The ceiling is far above the fewer than a hundred cycles the sequence needs.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic set_mode(input logic [2:0] m, input logic [2:0] e);
    op_mode_req <= m;
    tick(2);
    `CHK("op_mode_active", e, op_mode_active)
  endtask
  task automatic put_cfg(input can_mode_pkg::cfg_t v);
    cfg_in <= v;
    cfg_we <= 1'h1;
    tick(1);
    cfg_we <= 1'h0;
    tick(2);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    tick(6);
    rst <= 1'h0;
    tick(1);
    `CHK("op_mode_active", 3'h4, op_mode_active)
    c = '{1'h0, 1'h1, 3'h5, 2'h2, 1'h1, 1'h1, 1'h1};
    put_cfg(c);
    `CHK("cfg_active", c, cfg_active)
    `CHK("phase2_eff", 3'h5, phase2_eff)
    frame_received <= 1'h1;
    tick(1);
    frame_received <= 1'h0;
    tick(1);
    `CHK("capture_compare_unit", 1'h1, capture_compare_unit)
    for (int m = 0; m < 5; m++) set_mode(m[2:0], m[2:0]);
    set_mode(3'h7, 3'h4);
    set_mode(3'h0, 3'h0);
    frame_busy <= 1'h1;
    set_mode(3'h4, 3'h0);
    frame_busy <= 1'h0;
    set_mode(3'h4, 3'h4);
    set_mode(3'h2, 3'h2);
    put_cfg('0);
    `CHK("cfg_active", c, cfg_active)
    set_mode(3'h4, 3'h4);
    c.phase2_manual_select = 1'h0;
    put_cfg(c);
    `CHK("phase2_eff", 3'h1, phase2_eff)
    `CHK("buf_is_tx", 6'h2a, buf_is_tx)
    c.func_mode = 2'h3;
    put_cfg(c);
    `CHK("func_mode", 2'h0, cfg_active.func_mode)
    `CHK("buf_is_tx", 6'h00, buf_is_tx)
    remote_dom <= 1'h1;
    sample_point <= 1'h1;
    tick(1);
    remote_dom <= 1'h0;
    sample_point <= 1'h0;
    tick(1);
    `CHK("rx_bit", 1'h0, rx_bit)
    c.triple_sample_select = 1'h1;
    put_cfg(c);
    sample_tick <= 1'h1;
    tick(2);
    remote_dom <= 1'h1;
    tick(1);
    sample_tick <= 1'h0;
    sample_point <= 1'h1;
    tick(1);
    remote_dom <= 1'h0;
    sample_point <= 1'h0;
    tick(1);
    `CHK("rx_bit", 1'h1, rx_bit)
    tx_secondary_src_clock <= 1'h1;
    tx_secondary_src_we <= 1'h1;
    tick(1);
    tx_secondary_src_we <= 1'h0;
    tick(1);
    `CHK("can_tx_secondary_oe", 1'h1, can_tx_secondary_oe)
    can_clk_level <= 1'h1;
    tick(2);
    `CHK("can_tx_secondary", 1'h1, can_tx_secondary)
    tx_secondary_disable <= 1'h1;
    tick(1);
    tx_secondary_disable <= 1'h0;
    tick(1);
    `CHK("can_tx_secondary_oe", 1'h0, can_tx_secondary_oe)
    tx_secondary_src_clock <= 1'h0;
    tx_secondary_src_we <= 1'h1;
    tick(1);
    tx_secondary_src_we <= 1'h0;
    tick(2);
    `CHK("can_tx_secondary", 1'h0, can_tx_secondary)
    `CHK("can_tx_secondary_oe", 1'h1, can_tx_secondary_oe)
    set_mode(3'h1, 3'h1);
    op_mode_req <= 3'h7;
    remote_dom <= 1'h1;
    for (int i = 0; i < 40 && wake_event !== 1'h1; i++) tick(1);
    `CHK("wake_event", 1'h1, wake_event)
    remote_dom <= 1'h0;
    tick(2);
    `CHK("op_mode_active", 3'h0, op_mode_active)
    can_tx_core <= 1'h0;
    tick(3);
    `CHK("can_tx_primary", 1'h0, can_tx_primary)
    `CHK("can_tx_secondary", 1'h1, can_tx_secondary)
    end_sim();
  end
endmodule // can_mode_and_config_control_tb
